// ==== rtl/dct_pkg.sv ====
package dct_pkg;
  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [3:0] OFS_SHORT_CTRL  = 4'h0;
  localparam logic [3:0] OFS_SHARED_CTRL = 4'h1;
  localparam logic [3:0] OFS_WIDE_CTRL   = 4'h2;
  localparam logic [3:0] OFS_SHORT_INIT  = 4'h5;
  localparam logic [3:0] OFS_WIDE_INIT   = 4'h6;
  localparam logic [3:0] OFS_WIDE_HOLD   = 4'h7;
  localparam logic [3:0] OFS_WCAP_LO     = 4'h8;
  localparam logic [3:0] OFS_WCAP_HI     = 4'h9;
  localparam logic [3:0] OFS_SCAP_LO     = 4'ha;
  localparam logic [3:0] OFS_SCAP_HI     = 4'hb;
  // ************************************************************
  // control field positions
  // ************************************************************
  localparam int BIT_EN     = 7;
  localparam int BIT_SINGLE = 6;
  localparam int BIT_TOUT   = 5;
  localparam int BIT_CLKSEL = 4;
  localparam int BIT_MASK   = 1;
  localparam int BIT_PINSEL = 0;
  localparam int BIT_HI_FLG = 0;
  localparam int BIT_LO_FLG = 1;
  localparam int BIT_PP_LO  = 2;
  localparam int BIT_PP_HI  = 3;
  localparam int BIT_DEMOD  = 7;
  // ************************************************************
  // reset values and counts
  // ************************************************************
  localparam logic [7:0]  CTRL_RESET = 8'h00;
  localparam logic [7:0]  DATA_RESET = 8'h00;
  localparam logic [1:0]  PP_CODE    = 2'h3;
  localparam logic [7:0]  SHORT_TERM = 8'h01;
  localparam logic [15:0] WIDE_TERM  = 16'h0001;
  localparam logic [7:0]  SHORT_ONE  = 8'h01;
  localparam logic [15:0] WIDE_ONE   = 16'h0001;
  localparam logic [7:0]  PRE_ONE    = 8'h01;
endpackage

// ==== rtl/dct_timer.sv ====
`timescale 1ns/100ps
module dct_timer
  import dct_pkg::*;
#(
  parameter int unsigned DIV = 4
)(
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  input  wire logic [3:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic       timer_in,
  input  wire logic       port_data,
  output logic            timer_output_pin,
  output logic            short_timeout_irq,
  output logic            wide_timeout_irq
);

  // ************************************************************
  // state
  // ************************************************************
  logic [7:0]  sc;
  logic [7:0]  sh;
  logic [7:0]  wc;
  logic [7:0]  init8;
  logic [7:0]  init_lo;
  logic [7:0]  hold;
  logic [7:0]  t8;
  logic [15:0] t16;
  logic [7:0]  scap_hi;
  logic [7:0]  scap_lo;
  logic [15:0] wcap;
  logic [7:0]  pre;
  logic        tin_s1;
  logic        tin_s2;
  logic        tin_d;
  logic        t8_out;

  // ************************************************************
  // control register update
  // ************************************************************
  function automatic logic [7:0] ctrl_next(
    input logic [7:0] cur,
    input logic       wr,
    input logic [7:0] wd,
    input logic       term,
    input logic       go
  );
    logic [7:0] v;
    v = wr ? wd : cur;
    v[BIT_TOUT] = (cur[BIT_TOUT] & ~(wr & wd[BIT_TOUT])) | term;
    v[BIT_EN] = go | (v[BIT_EN] & ~(term & cur[BIT_SINGLE] & ~wr));
    return v;
  endfunction

  // ************************************************************
  // decode
  // ************************************************************
  wire wr_sc   = reg_wr & (reg_addr == OFS_SHORT_CTRL);
  wire wr_sh   = reg_wr & (reg_addr == OFS_SHARED_CTRL);
  wire wr_wc   = reg_wr & (reg_addr == OFS_WIDE_CTRL);
  wire wr_i8   = reg_wr & (reg_addr == OFS_SHORT_INIT);
  wire wr_ilo  = reg_wr & (reg_addr == OFS_WIDE_INIT);
  wire wr_hold = reg_wr & (reg_addr == OFS_WIDE_HOLD);

  wire [15:0] init16 = {hold, init_lo};
  wire pp    = ({sh[BIT_PP_HI], sh[BIT_PP_LO]} == PP_CODE);
  wire demod = sh[BIT_DEMOD];
  wire rise  = tin_s2 & ~tin_d;
  wire fall  = ~tin_s2 & tin_d;
  wire dm_on = demod & sc[BIT_EN];
  wire cap_hi = dm_on & fall;
  wire cap_lo = dm_on & rise;
  wire dm_restart = cap_hi | cap_lo;
  wire w_edge = demod & wc[BIT_EN] & (rise | fall);

  // free-running divider; first tick lands anywhere
  wire div_tick = (pre == 8'(DIV - 1));
  wire s_tick = sc[BIT_EN] & (sc[BIT_CLKSEL] ? div_tick : 1'b1);
  wire w_tick = wc[BIT_EN] & (wc[BIT_CLKSEL] ? div_tick : 1'b1);

  wire t8_term  = s_tick & ~demod & (t8 == SHORT_TERM);
  wire t16_term = w_tick & (t16 == WIDE_TERM);
  wire go8  = pp & t16_term & ~sc[BIT_EN];
  wire go16 = pp & t8_term & ~wc[BIT_EN];
  wire start8  = wr_sc & reg_wdata[BIT_EN] & ~sc[BIT_EN];
  wire start16 = wr_wc & reg_wdata[BIT_EN] & ~wc[BIT_EN];
  wire load8  = start8 | go8 | (t8_term & ~sc[BIT_SINGLE]);
  wire load16 = start16 | go16 | (t16_term & ~wc[BIT_SINGLE]);

  wire [7:0] next_sc = ctrl_next(sc, wr_sc, reg_wdata, t8_term, go8);
  wire [7:0] next_wc = ctrl_next(wc, wr_wc, reg_wdata, t16_term, go16);
  wire [7:0] sh_w = wr_sh ? reg_wdata : sh;
  wire next_hi_flg = (sh[BIT_HI_FLG] & ~(wr_sh & reg_wdata[BIT_HI_FLG]))
                     | cap_hi;
  wire next_lo_flg = (sh[BIT_LO_FLG] & ~(wr_sh & reg_wdata[BIT_LO_FLG]))
                     | cap_lo;
  wire [7:0] next_sh = {sh_w[7:2], next_lo_flg, next_hi_flg};

  // counters advance only while clk_en is high; clk_en low freezes them
  wire [7:0] t8_step = demod ? t8 + SHORT_ONE : t8 - SHORT_ONE;
  wire [7:0] next_t8 = load8      ? init8 :
                       dm_restart ? DATA_RESET :
                       s_tick     ? t8_step : t8;
  wire [15:0] next_t16 = load16 ? init16 :
                         w_tick ? t16 - WIDE_ONE : t16;

  wire [7:0] rd_mux =
    (reg_addr == OFS_SHORT_CTRL)  ? sc :
    (reg_addr == OFS_SHARED_CTRL) ? sh :
    (reg_addr == OFS_WIDE_CTRL)   ? wc :
    (reg_addr == OFS_SHORT_INIT)  ? init8 :
    (reg_addr == OFS_WIDE_INIT)   ? init_lo :
    (reg_addr == OFS_WIDE_HOLD)   ? hold :
    (reg_addr == OFS_WCAP_LO)     ? wcap[7:0] :
    (reg_addr == OFS_WCAP_HI)     ? wcap[15:8] :
    (reg_addr == OFS_SCAP_LO)     ? scap_lo :
    (reg_addr == OFS_SCAP_HI)     ? scap_hi : DATA_RESET;

  // ************************************************************
  // pin synchroniser and divider
  // ************************************************************
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tin_s1 <= 1'b0;
      tin_s2 <= 1'b0;
      tin_d  <= 1'b0;
      pre    <= DATA_RESET;
    end
    else if (clk_en)
    begin
      tin_s1 <= timer_in;
      tin_s2 <= tin_s1;
      tin_d  <= tin_s2;
      pre    <= div_tick ? DATA_RESET : pre + PRE_ONE;
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sc      <= CTRL_RESET;
      sh      <= CTRL_RESET;
      wc      <= CTRL_RESET;
      init8   <= DATA_RESET;
      init_lo <= DATA_RESET;
      hold    <= DATA_RESET;
    end
    else if (clk_en)
    begin
      sc <= next_sc;
      sh <= next_sh;
      wc <= next_wc;
      if (wr_i8)
        init8 <= reg_wdata;
      if (wr_ilo)
        init_lo <= reg_wdata;
      if (wr_hold)
        hold <= reg_wdata;
    end
  end

  // ************************************************************
  // counters and captures
  // ************************************************************
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      t8      <= DATA_RESET;
      t16     <= {DATA_RESET, DATA_RESET};
      scap_hi <= DATA_RESET;
      scap_lo <= DATA_RESET;
      wcap    <= {DATA_RESET, DATA_RESET};
      t8_out  <= 1'b0;
    end
    else if (clk_en)
    begin
      t8  <= next_t8;
      t16 <= next_t16;
      if (cap_hi)
        scap_hi <= t8;
      if (cap_lo)
        scap_lo <= t8;
      if (w_edge)
        wcap <= t16;
      if (t8_term)
        t8_out <= ~t8_out;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata         <= DATA_RESET;
      timer_output_pin  <= 1'b0;
      short_timeout_irq <= 1'b0;
      wide_timeout_irq  <= 1'b0;
    end
    else if (clk_en)
    begin
      reg_rdata         <= rd_mux;
      timer_output_pin  <= sc[BIT_PINSEL] ? t8_out : port_data;
      short_timeout_irq <= sc[BIT_TOUT] & sc[BIT_MASK];
      wide_timeout_irq  <= wc[BIT_TOUT] & wc[BIT_MASK];
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking dc @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  high_capture_a: assert property (
    clk_en && cap_hi |=> scap_hi == $past(t8))
    else $error("high phase capture wrong");
  low_capture_a: assert property (
    clk_en && cap_lo |=> scap_lo == $past(t8) && t8 == DATA_RESET)
    else $error("low phase capture or restart wrong");
  wcap_hi_ro_a: assert property (
    reg_wr && reg_addr == OFS_WCAP_HI && !w_edge |=> $stable(wcap))
    else $error("wide capture high changed by write");
  wcap_lo_ro_a: assert property (
    reg_wr && reg_addr == OFS_WCAP_LO && !w_edge |=> $stable(wcap))
    else $error("wide capture low changed by write");
  hold_write_a: assert property (
    clk_en && wr_hold
    |=> hold == $past(reg_wdata))
    else $error("hold register write lost");
  start_run_a: assert property (
    clk_en && start8 |=> sc[BIT_EN])
    else $error("short counter did not start");
  start_load_a: assert property (
    clk_en && start8 |=> t8 == $past(init8))
    else $error("restart did not reload");
  modulo_reload_a: assert property (
    clk_en && t8_term && !sc[BIT_SINGLE] && !wr_sc
    |=> t8 == $past(init8) && sc[BIT_EN])
    else $error("modulo reload failed");
  single_stop_a: assert property (
    clk_en && t8_term && sc[BIT_SINGLE] && !wr_sc && !go8
    |=> !sc[BIT_EN])
    else $error("single pass did not stop");
  tout_irq_a: assert property (
    clk_en && t8_term ##1 clk_en
    |=> short_timeout_irq == $past(sc[BIT_MASK]))
    else $error("timeout request wrong");
  flag_keep_a: assert property (
    clk_en && sc[BIT_TOUT] && !(wr_sc && reg_wdata[BIT_TOUT])
    |=> sc[BIT_TOUT])
    else $error("timeout flag lost");
  pin_route_a: assert property (
    clk_en |=> timer_output_pin ==
      ($past(sc[BIT_PINSEL]) ? $past(t8_out) : $past(port_data)))
    else $error("output pin routing wrong");
  pingpong_a: assert property (
    clk_en && pp && t8_term && !wc[BIT_EN] && !wr_wc
    |=> wc[BIT_EN] && t16 == $past(init16))
    else $error("alternate hand-over failed");

  timeout_c: cover property (clk_en && t8_term && sc[BIT_MASK]);
  capture_c: cover property (clk_en && cap_hi ##[1:50] clk_en && cap_lo);
  pingpong_c: cover property (clk_en && go16 ##[1:100] clk_en && go8);

endmodule

// ==== tb/dct_pin_src.sv ====
`timescale 1ns/100ps
module dct_pin_src (
  input  wire logic sys_clk,
  output logic      timer_in
);
  // ****************************************
  // demodulation input source
  // ****************************************
  initial timer_in = 1'b0;
  // rise, high phase, fall, low phase, rise
  task automatic phases(input int hi_n, input int lo_n);
    @(negedge sys_clk);
    timer_in = 1'b1;
    repeat (hi_n) @(negedge sys_clk);
    timer_in = 1'b0;
    repeat (lo_n) @(negedge sys_clk);
    timer_in = 1'b1;
    repeat (6) @(negedge sys_clk);
  endtask
endmodule

// ==== tb/tb_dual_counter_timer_capture.sv ====
`timescale 1ns/100ps
module tb_dual_counter_timer_capture;
  import dct_pkg::*;
  typedef struct {
    logic [7:0] init;
    logic [7:0] ctrl;
    int         wait_n;
    logic [7:0] rb;
  } dct_row_type;
  logic        sys_clk;
  logic        rst_n;
  logic        clk_en;
  logic [3:0]  reg_addr;
  logic        reg_wr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic        timer_in;
  logic        port_data;
  logic        timer_output_pin;
  logic        short_timeout_irq;
  logic        wide_timeout_irq;
  int          bad_count;
  int          comparisons;
  int          cycles;
  int          k;
  logic        pin_prev;
  logic [7:0]  rd_a;
  logic [7:0]  rd_b;
  dct_row_type rows [4] = '{'{8'h02, 8'hc2, 3, 8'h62},
    '{8'h05, 8'h82, 6, 8'ha2}, '{8'hff, 8'hc2, 256, 8'h62},
    '{8'h03, 8'h83, 4, 8'ha3}};
  dct_timer #(.DIV(2)) i_dut (
    .sys_clk           (sys_clk),
    .rst_n             (rst_n),
    .clk_en            (clk_en),
    .reg_addr          (reg_addr),
    .reg_wr            (reg_wr),
    .reg_wdata         (reg_wdata),
    .reg_rdata         (reg_rdata),
    .timer_in          (timer_in),
    .port_data         (port_data),
    .timer_output_pin  (timer_output_pin),
    .short_timeout_irq (short_timeout_irq),
    .wide_timeout_irq  (wide_timeout_irq)
  );
  dct_pin_src i_pin (
    .sys_clk  (sys_clk),
    .timer_in (timer_in)
  );
  // ****************************************
  // clock, timeout and shared tasks
  // ****************************************
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask
  task automatic wait_irq(input logic wide, output int n, output logic p);
    n = 0;
    p = timer_output_pin;
    while ((wide ? wide_timeout_irq : short_timeout_irq) !== 1'b1
           && n < 600)
    begin
      p = timer_output_pin;
      @(negedge sys_clk);
      n++;
    end
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    {rst_n, reg_wr, port_data, reg_addr, reg_wdata} = '0;
    clk_en = 1'b1;
    {bad_count, comparisons, cycles} = '0;
    repeat (6) @(negedge sys_clk);
    rst_n = 1'b1;
    rd(OFS_SHORT_CTRL, rd_a);
    chk(rd_a, CTRL_RESET);
    chk({short_timeout_irq, wide_timeout_irq, timer_output_pin}, 0);
    port_data = 1'b1;
    repeat (2) @(negedge sys_clk);
    chk(timer_output_pin, 1);
    for (int a = 8; a < 12; a++)
    begin
      wr(a[3:0], 8'hff);
      rd(a[3:0], rd_a);
      chk(rd_a, 8'h00);
    end
    wr(OFS_WIDE_HOLD, 8'h5a);
    rd(OFS_WIDE_HOLD, rd_a);
    chk(rd_a, 8'h5a);
    rd(4'hc, rd_a);
    chk(rd_a, 8'h00);
    foreach (rows[i])
    begin
      wr(OFS_SHORT_CTRL, 8'h00);
      wr(OFS_SHORT_CTRL, 8'h20);
      wr(OFS_SHORT_INIT, rows[i].init);
      wr(OFS_SHORT_CTRL, rows[i].ctrl);
      wait_irq(0, k, pin_prev);
      chk(k, rows[i].wait_n);
      chk(timer_output_pin, rows[i].ctrl[0] ? !pin_prev : port_data);
      rd(OFS_SHORT_CTRL, rd_a);
      chk(rd_a, rows[i].rb);
    end
    // masked time-out and write-one-to-clear
    wr(OFS_SHORT_CTRL, 8'h20);
    wr(OFS_SHORT_INIT, 8'h03);
    wr(OFS_SHORT_CTRL, 8'hc0);
    repeat (10) @(negedge sys_clk);
    chk(short_timeout_irq, 0);
    wr(OFS_SHORT_CTRL, 8'h40);
    rd(OFS_SHORT_CTRL, rd_a);
    chk(rd_a, 8'h60);
    wr(OFS_SHORT_CTRL, 8'h20);
    rd(OFS_SHORT_CTRL, rd_a);
    chk(rd_a, 8'h00);
    // stop mid-count, restart reloads
    wr(OFS_SHORT_INIT, 8'h0a);
    wr(OFS_SHORT_CTRL, 8'h82);
    repeat (4) @(negedge sys_clk);
    wr(OFS_SHORT_CTRL, 8'h02);
    wr(OFS_SHORT_CTRL, 8'h82);
    wait_irq(0, k, pin_prev);
    chk(k, 11);
    // divided clock, shortened first tick
    wr(OFS_SHORT_CTRL, 8'h20);
    wr(OFS_SHORT_INIT, 8'h06);
    wr(OFS_SHORT_CTRL, 8'h92);
    wait_irq(0, k, pin_prev);
    chk(k >= 12 && k <= 13, 1);
    // demodulation captures
    wr(OFS_SHORT_CTRL, 8'h20);
    wr(OFS_SHARED_CTRL, 8'h83);
    wr(OFS_SHORT_CTRL, 8'h80);
    wr(OFS_WIDE_CTRL, 8'h80);
    i_pin.phases(20, 12);
    rd(OFS_SCAP_HI, rd_a);
    rd(OFS_SCAP_LO, rd_b);
    chk(rd_a - rd_b, 8);
    rd(OFS_SHARED_CTRL, rd_a);
    chk(rd_a, 8'h83);
    rd(OFS_WCAP_HI, rd_a);
    chk(rd_a, 8'h59);
    wr(OFS_SHARED_CTRL, 8'h03);
    // alternating counters
    wr(OFS_SHORT_CTRL, 8'h20);
    wr(OFS_WIDE_CTRL, 8'h20);
    wr(OFS_SHORT_INIT, 8'h04);
    wr(OFS_WIDE_INIT, 8'h05);
    wr(OFS_WIDE_HOLD, 8'h00);
    wr(OFS_WIDE_CTRL, 8'h42);
    wr(OFS_SHORT_CTRL, 8'h42);
    wr(OFS_SHARED_CTRL, 8'h0c);
    wr(OFS_SHORT_CTRL, 8'hc2);
    wait_irq(1, k, pin_prev);
    chk(k >= 9 && k <= 11, 1);
    rd(OFS_WIDE_CTRL, rd_a);
    chk(rd_a, 8'h62);
    wr(OFS_SHARED_CTRL, 8'h00);
    // clock enable low freezes the count
    wr(OFS_SHORT_CTRL, 8'h20);
    wr(OFS_SHORT_INIT, 8'h05);
    wr(OFS_SHORT_CTRL, 8'hc2);
    clk_en = 1'b0;
    repeat (10) @(negedge sys_clk);
    chk(short_timeout_irq, 0);
    clk_en = 1'b1;
    wait_irq(0, k, pin_prev);
    chk(k, 6);
    test_done();
  end
endmodule
